// ===== bench/pmp_array_tb_top.sv
// self-checking bench for force load, observe, keepers, security and fuse reads
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module pmp_array_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic force_hv, force_clk, reg_select, parity_select;
  logic [23:0] io_in, io_driven, io_out_q, io_oe_q;
  logic [23:0] exp_p = 24'h0, exp_b = 24'h0;
  logic [23:0] pats [4] = '{24'h3cc3a5, 24'hc35a3c, 24'h0ff0aa, 24'hf00f55};
  logic [pmp_pkg::NUM_MC*pmp_pkg::MC_FUSE_W-1:0] afuse = '0;
  // cell 0 feeds back its buried flop input so the feedback select is exercised
  logic [191:0] cfgf = 192'h3;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sec = 1'b0, observe_hv = 1'b0, ce = 1'b1;
  int fail_count = 0, num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  pmp_array u_dut (.ref_clk(ref_clk), .reset(reset), .ce(ce), .ded_in(14'h0000),
    .ded_in_driven(14'h3fff), .io_in(io_in), .io_driven(io_driven), .io_out_q(io_out_q),
    .io_oe_q(io_oe_q), .force_hv(force_hv), .force_clk(force_clk), .reg_select(reg_select),
    .parity_select(parity_select), .observe_hv(observe_hv), .array_fuses(afuse),
    .preset_fuses('0), .cfg_fuses(cfgf), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  pmp_tester u_tester (.ref_clk(ref_clk), .force_hv(force_hv), .force_clk(force_clk),
    .reg_select(reg_select), .parity_select(parity_select), .io_in(io_in),
    .io_driven(io_driven));
  // ************************************************************
  // bus and force-load helpers
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK($sformatf("reg_%h", a), e, reg_rdata_q);
  endtask
  task automatic fz(input logic [31:0] idx, input logic [31:0] e);
    wr(pmp_pkg::OFF_FUSE_ADDR, idx);
    rd(pmp_pkg::OFF_FUSE_DATA, e);
  endtask
  function automatic logic [23:0] upd(input logic [23:0] cur, src, input logic par);
    logic [23:0] r;
    r = cur;
    for (int m = 0; m < 24; m++) begin
      if (m % 2 == int'(par)) r[m] = src[m | 1];
    end
    return r;
  endfunction
  task automatic pl(input logic par, rsel, input logic [23:0] d, src, input logic drv);
    u_tester.preload(par, rsel, d, drv);
    if (!sec && rsel) exp_b = upd(exp_b, src, par);
    if (!sec && !rsel) exp_p = upd(exp_p, src, par);
    rd(pmp_pkg::OFF_PRIMARY, {8'h00, exp_p});
    rd(pmp_pkg::OFF_BURIED, sec ? 32'h0 : {8'h00, exp_b});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    complete_run;
  end
  initial begin
    // control terms see a line and its complement, so they stay false
    for (int m = 0; m < 24; m++) begin
      for (int t = 0; t <= pmp_pkg::T_OE; t++) begin
        afuse[m*pmp_pkg::MC_FUSE_W + t*pmp_pkg::BUS_W +: 2] = 2'h3;
      end
    end
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rd(pmp_pkg::OFF_CTRL, 32'h0);
    rd(pmp_pkg::OFF_PRIMARY, 32'h0);
    rd(pmp_pkg::OFF_BURIED, 32'h0);
    rd(8'h14, 32'h0);
    // a write while the clock enable is low must be ignored
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(pmp_pkg::OFF_CTRL, 32'h1);
    ce <= 1'b1;
    rd(pmp_pkg::OFF_CTRL, 32'h0);
    $display("reset test done");
    fz(32'h0, 32'h1);
    fz(32'h5, 32'h0);
    fz(32'h11840, 32'h0);
    $display("fuse test done");
    for (int g = 0; g < 4; g++) begin
      pl(g[0], g[1], pats[g], pats[g], 1'b1);
    end
    pl(1'b0, 1'b0, 24'h0, ~pats[3], 1'b0);
    $display("force test done");
    wr(pmp_pkg::OFF_CTRL, 32'h1);
    rd(pmp_pkg::OFF_CTRL, 32'h1);
    wr(pmp_pkg::OFF_CTRL, 32'h2);
    rd(pmp_pkg::OFF_CTRL, 32'h2);
    pl(1'b1, 1'b0, 24'h9669c3, 24'h9669c3, 1'b1);
    pl(1'b1, 1'b0, 24'h0, 24'h9669c3, 1'b0);
    pl(1'b1, 1'b0, 24'h5aa5f0, 24'h5aa5f0, 1'b1);
    $display("keeper test done");
    // cell 0 gets a live enable term so the observed value is driven there
    @(posedge ref_clk);
    observe_hv <= 1'b1;
    afuse[pmp_pkg::T_OE*pmp_pkg::BUS_W +: 2] <= 2'h0;
    repeat (8) @(posedge ref_clk);
    #1;
    `CHK("obs_out", exp_b, io_out_q);
    `CHK("obs_oe", 24'h000001, io_oe_q);
    @(posedge ref_clk);
    observe_hv <= 1'b0;
    afuse[pmp_pkg::T_OE*pmp_pkg::BUS_W +: 2] <= 2'h3;
    $display("observe test done");
    wr(pmp_pkg::OFF_CTRL, 32'h6);
    wr(pmp_pkg::OFF_CTRL, 32'h0);
    rd(pmp_pkg::OFF_CTRL, 32'h6);
    sec = 1'b1;
    pl(1'b0, 1'b0, 24'hffffff, 24'hffffff, 1'b1);
    fz(32'h5, 32'h1);
    $display("secure test done");
    complete_run;
  end
endmodule

// ===== bench/pmp_tester.sv
// tester model that drives the force-load pins of the macrocell array
module pmp_tester (
  input wire logic ref_clk,
  output logic force_hv,
  output logic force_clk,
  output logic reg_select,
  output logic parity_select,
  output logic [23:0] io_in,
  output logic [23:0] io_driven
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    force_hv = 1'b0;
    force_clk = 1'b0;
    reg_select = 1'b0;
    parity_select = 1'b0;
    io_in = 24'h000000;
    io_driven = 24'hffffff;
  end
  task automatic preload(input logic par, rsel, input logic [23:0] d, input logic drv);
    @(posedge ref_clk);
    force_hv <= 1'b1;
    repeat (6) @(posedge ref_clk);
    parity_select <= par;
    reg_select <= rsel;
    io_driven <= {24{drv}};
    // released pins must not keep showing the old level
    io_in <= drv ? d : ~io_in;
    repeat (6) @(posedge ref_clk);
    force_clk <= 1'b1;
    repeat (8) @(posedge ref_clk);
    force_clk <= 1'b0;
    repeat (4) @(posedge ref_clk);
    force_hv <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

// ===== hw/pmp_array.sv
// array top: pin synchronisers, keepers, global bus, force load, observe, register port
// Notes on behaviour
// - force mode loads any register either value
// - odd pin level sets target, ignores configuration
// - force clock pulse loads twelve registers
// - two selects pick parity and flop bank
// - observe mode drives buried flops when enabled
// - secured device reads every fuse programmed
// - security fuse blocks force and observe
// - pin keepers off after reset
// - enabled keeper holds last driven level
// - external driver overrides keeper at once
// - keeper enable set only by configuration
// - 24 macrocells, 17 terms, 172 lines
// - five terms are dedicated controls
// - twelve terms form three sums of four
// - eight presets in four/two groups
// - dedicated inputs true and complemented
// - six bus lines per macrocell
// - feedback from buried flop input or output
// - legacy mode drops toggle, pin clock, feedback
// - reset clears every register
module pmp_array (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [pmp_pkg::NUM_DIN-1:0] ded_in,
  input wire logic [pmp_pkg::NUM_DIN-1:0] ded_in_driven,
  input wire logic [pmp_pkg::NUM_MC-1:0] io_in,
  input wire logic [pmp_pkg::NUM_MC-1:0] io_driven,
  output logic [pmp_pkg::NUM_MC-1:0] io_out_q,
  output logic [pmp_pkg::NUM_MC-1:0] io_oe_q,
  input wire logic force_hv,
  input wire logic force_clk,
  input wire logic reg_select,
  input wire logic parity_select,
  input wire logic observe_hv,
  input wire logic [pmp_pkg::NUM_MC*pmp_pkg::MC_FUSE_W-1:0] array_fuses,
  input wire logic [pmp_pkg::NUM_PRESET*pmp_pkg::BUS_W-1:0] preset_fuses,
  input wire logic [pmp_pkg::NUM_MC*pmp_pkg::CFG_W-1:0] cfg_fuses,
  input wire logic [pmp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmp_pkg::DATA_W-1:0] reg_rdata_q
);
  localparam int NM = pmp_pkg::NUM_MC;
  localparam int ND = pmp_pkg::NUM_DIN;
  localparam int SYNC_W = 2 * ND + 2 * NM + 5;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // three stages; a bit only moves once stages two and three agree,
  // which costs a cycle but rejects a single-cycle glitch
  logic [SYNC_W-1:0] sync_raw, sync1_q, sync2_q, sync3_q, filt_q;
  logic [ND-1:0] din_f, din_drv_f;
  logic [NM-1:0] io_f, io_drv_f;
  logic force_hv_f, force_clk_f, reg_sel_f, par_sel_f, obs_hv_f;

  assign sync_raw = {observe_hv, parity_select, reg_select, force_clk, force_hv,
                     io_driven, io_in, ded_in_driven, ded_in};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q <= '0;
    end else if (ce) begin
      sync1_q <= sync_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= (~(sync2_q ^ sync3_q) & sync2_q) | ((sync2_q ^ sync3_q) & filt_q);
    end
  end

  assign din_f = filt_q[0 +: ND];
  assign din_drv_f = filt_q[ND +: ND];
  assign io_f = filt_q[2*ND +: NM];
  assign io_drv_f = filt_q[2*ND+NM +: NM];
  assign force_hv_f = filt_q[2*ND+2*NM];
  assign force_clk_f = filt_q[2*ND+2*NM+1];
  assign reg_sel_f = filt_q[2*ND+2*NM+2];
  assign par_sel_f = filt_q[2*ND+2*NM+3];
  assign obs_hv_f = filt_q[2*ND+2*NM+4];

  // ************************************************************
  // configuration register and security
  // ************************************************************
  logic legacy_q, keeper_en_q, secure_q;
  logic [pmp_pkg::FUSE_IDX_W-1:0] fuse_addr_q;
  logic ctrl_wr;

  assign ctrl_wr = reg_wr && (reg_addr == pmp_pkg::OFF_CTRL);

  // keeper enable only from configuration write
  // the write is refused once secured, so the setting is frozen
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      legacy_q <= pmp_pkg::LEGACY_RST;
      keeper_en_q <= pmp_pkg::KEEPER_RST;
      secure_q <= pmp_pkg::SECURE_RST;
    end else if (ce && ctrl_wr && !secure_q) begin
      legacy_q <= reg_wdata[pmp_pkg::CTRL_LEGACY];
      keeper_en_q <= reg_wdata[pmp_pkg::CTRL_KEEPER];
      secure_q <= reg_wdata[pmp_pkg::CTRL_SECURE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fuse_addr_q <= '0;
    end else if (ce && reg_wr && (reg_addr == pmp_pkg::OFF_FUSE_ADDR)) begin
      fuse_addr_q <= reg_wdata[pmp_pkg::FUSE_IDX_W-1:0];
    end
  end

  // ************************************************************
  // pin keepers
  // ************************************************************
  logic [ND-1:0] din_lvl, din_keep_q;
  logic [NM-1:0] io_lvl, io_keep_q;

  // an external driver always wins over the held level
  // undriven pin keeps last level when enabled
  always_comb begin
    for (int i = 0; i < ND; i++) begin
      din_lvl[i] = (din_drv_f[i] || !keeper_en_q) ? din_f[i] : din_keep_q[i];
    end
    for (int i = 0; i < NM; i++) begin
      if (io_oe_q[i]) begin
        io_lvl[i] = io_out_q[i];
      end else begin
        io_lvl[i] = (io_drv_f[i] || !keeper_en_q) ? io_f[i] : io_keep_q[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      din_keep_q <= '0;
      io_keep_q <= '0;
    end else if (ce) begin
      din_keep_q <= din_lvl;
      io_keep_q <= io_lvl;
    end
  end

  // ************************************************************
  // global bus and preset terms
  // ************************************************************
  logic [pmp_pkg::BUS_W-1:0] gbus;
  logic [NM-1:0] primary_vec, buried_vec, feedback_vec, out_val, oe_term;
  logic [pmp_pkg::NUM_PRESET-1:0] preset_term;

  for (genvar i = 0; i < ND; i++) begin : g_din_bus
    assign gbus[2*i] = din_lvl[i];
    assign gbus[2*i+1] = ~din_lvl[i];
  end

  // feedback, primary flop, pin, true and false
  for (genvar m = 0; m < NM; m++) begin : g_mc_bus
    localparam int B = pmp_pkg::MC_BUS_BASE + pmp_pkg::MC_BUS_LINES * m;
    assign gbus[B] = feedback_vec[m];
    assign gbus[B+1] = ~feedback_vec[m];
    assign gbus[B+2] = primary_vec[m];
    assign gbus[B+3] = ~primary_vec[m];
    assign gbus[B+4] = io_lvl[m];
    assign gbus[B+5] = ~io_lvl[m];
  end

  for (genvar p = 0; p < pmp_pkg::NUM_PRESET; p++) begin : g_preset
    assign preset_term[p] = &(gbus | ~preset_fuses[p*pmp_pkg::BUS_W +: pmp_pkg::BUS_W]);
  end

  // ************************************************************
  // force load and observe modes
  // ************************************************************
  logic force_active, observe_active, force_clk_prev_q, force_pulse;

  // security fuse disables both test modes
  assign force_active = force_hv_f & ~secure_q;
  assign observe_active = obs_hv_f & ~secure_q & ~force_active;
  // one rising edge of the force clock, one load
  assign force_pulse = force_active & force_clk_f & ~force_clk_prev_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      force_clk_prev_q <= 1'h0;
    end else if (ce) begin
      force_clk_prev_q <= force_clk_f;
    end
  end

  // ************************************************************
  // macrocells
  // ************************************************************
  // 24 macrocells
  for (genvar m = 0; m < NM; m++) begin : g_mc
    logic load;
    // parity select picks even or odd cells
    // cells of other parity see no load
    assign load = force_pulse & (par_sel_f == ((m % 2) == 1));

    pmp_macrocell #(
      .BUS_W(pmp_pkg::BUS_W),
      .NUM_TERMS(pmp_pkg::NUM_TERMS)
    ) u_mc (
      .ref_clk(ref_clk),
      .reset(reset),
      .ce(ce),
      .bus(gbus),
      .fuses(array_fuses[m*pmp_pkg::MC_FUSE_W +: pmp_pkg::MC_FUSE_W]),
      .cfg(cfg_fuses[m*pmp_pkg::CFG_W +: pmp_pkg::CFG_W]),
      .legacy(legacy_q),
      .preset_term(preset_term[pmp_pkg::preset_group(m)]),
      .pin_clk(din_lvl[0]),
      .force_mode(force_active),
      .force_load(load),
      .force_buried(reg_sel_f),
      // odd pin of the pair, synchronised and kept level
      .force_data(io_lvl[m | 1]),
      .primary_q(primary_vec[m]),
      .buried_q(buried_vec[m]),
      .second_feedback(feedback_vec[m]),
      .out_val(out_val[m]),
      .oe_term(oe_term[m])
    );
  end

  // ************************************************************
  // output buffers
  // ************************************************************
  // pins float during force mode so the tester can drive them
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      io_out_q <= '0;
      io_oe_q <= '0;
    end else if (ce) begin
      for (int m = 0; m < NM; m++) begin
        io_oe_q[m] <= ~force_active & oe_term[m];
        if (observe_active) begin
          io_out_q[m] <= buried_vec[m];
        end else begin
          io_out_q[m] <= cfg_fuses[m*pmp_pkg::CFG_W + pmp_pkg::CFG_POL] ? out_val[m]
                                                                       : ~out_val[m];
        end
      end
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  logic [pmp_pkg::FUSE_TOTAL-1:0] fuse_all;
  logic fuse_bit;
  logic [pmp_pkg::DATA_W-1:0] rd_val;

  assign fuse_all = {cfg_fuses, preset_fuses, array_fuses};
  assign fuse_bit = (fuse_addr_q < pmp_pkg::FUSE_IDX_W'(pmp_pkg::FUSE_TOTAL))
                    ? fuse_all[fuse_addr_q] : 1'h0;

  always_comb begin
    rd_val = '0;
    unique case (reg_addr)
      pmp_pkg::OFF_CTRL: rd_val = {29'h0, secure_q, keeper_en_q, legacy_q};
      pmp_pkg::OFF_PRIMARY: rd_val = {8'h00, primary_vec};
      pmp_pkg::OFF_BURIED: rd_val = secure_q ? 32'h0 : {8'h00, buried_vec};
      pmp_pkg::OFF_FUSE_ADDR: rd_val = {15'h0, fuse_addr_q};
      // secured part reads every fuse as programmed
      pmp_pkg::OFF_FUSE_DATA: rd_val = {31'h0, secure_q | fuse_bit};
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_q <= '0;
    end else if (ce) begin
      reg_rdata_q <= reg_rd ? rd_val : '0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_even_primary_pulse;
    ce && force_pulse && !par_sel_f && !reg_sel_f;
  endsequence

  sequence s_odd_buried_pulse;
    ce && force_pulse && par_sel_f && reg_sel_f;
  endsequence

  a_force_even_primary: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_even_primary_pulse |=> primary_vec[0] == $past(io_lvl[1])
                             && primary_vec[2] == $past(io_lvl[3]))
    else $error("force pulse did not load even primary flops");

  a_force_odd_buried: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_odd_buried_pulse |=> buried_vec[1] == $past(io_lvl[1]) && $stable(primary_vec[1]))
    else $error("force pulse did not load odd buried flops");

  a_unselected_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_even_primary_pulse |=> $stable(primary_vec[1]) && $stable(buried_vec[0]))
    else $error("unselected register changed on force pulse");

  a_fuse_concealed: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && reg_rd && reg_addr == pmp_pkg::OFF_FUSE_DATA && secure_q |=> reg_rdata_q[0])
    else $error("secured fuse read back unprogrammed");

  a_secure_inhibit: assert property (
    @(posedge ref_clk) disable iff (reset)
    secure_q |-> !force_active && !observe_active && !force_pulse)
    else $error("test mode active on secured part");

  a_observe_drive: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && observe_active && oe_term[0] |=> io_oe_q[0] && io_out_q[0] == $past(buried_vec[0]))
    else $error("observe mode did not show buried flop");

  a_keeper_default: assert property (
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> !keeper_en_q)
    else $error("keeper enabled after reset");

  a_keeper_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
    keeper_en_q && !io_drv_f[0] && !io_oe_q[0] |-> io_lvl[0] == io_keep_q[0])
    else $error("keeper did not hold undriven pin");

  a_external_override: assert property (
    @(posedge ref_clk) disable iff (reset)
    io_drv_f[0] && !io_oe_q[0] |-> io_lvl[0] == io_f[0])
    else $error("keeper overrode external driver");

  a_keeper_locked: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && ctrl_wr && secure_q |=> $stable(keeper_en_q) && secure_q)
    else $error("keeper setting changed after securing");

  a_power_clear: assert property (
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> primary_vec == 24'h0 && buried_vec == 24'h0 && !force_active)
    else $error("registers not cleared by reset");
endmodule

// ===== hw/pmp_macrocell.sv
// one macrocell: 17 product terms, sum terms, primary and buried flops
module pmp_macrocell #(
  parameter int BUS_W = pmp_pkg::BUS_W,
  parameter int NUM_TERMS = pmp_pkg::NUM_TERMS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [BUS_W-1:0] bus,
  input wire logic [NUM_TERMS*BUS_W-1:0] fuses,
  input wire logic [pmp_pkg::CFG_W-1:0] cfg,
  input wire logic legacy,
  input wire logic preset_term,
  input wire logic pin_clk,
  input wire logic force_mode,
  input wire logic force_load,
  input wire logic force_buried,
  input wire logic force_data,
  output logic primary_q,
  output logic buried_q,
  output logic second_feedback,
  output logic out_val,
  output logic oe_term
);
  logic [NUM_TERMS-1:0] term;
  logic sum_a, sum_b, sum_c;
  logic dt1, buried_flop_input;
  logic clk1, clk2, clk1_prev_q, clk2_prev_q, rise1, rise2;
  logic t1, t2;

  for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
    assign term[t] = &(bus | ~fuses[t*BUS_W +: BUS_W]);
  end

  assign sum_a = |term[pmp_pkg::T_SUM_BASE +: pmp_pkg::SUM_TERMS];
  assign sum_b = |term[pmp_pkg::T_SUM_BASE + pmp_pkg::SUM_TERMS +: pmp_pkg::SUM_TERMS];
  assign sum_c = |term[pmp_pkg::T_SUM_BASE + 2 * pmp_pkg::SUM_TERMS +: pmp_pkg::SUM_TERMS];
  assign buried_flop_input = sum_c;

  always_comb begin
    dt1 = sum_a;
    out_val = primary_q;
    if (!cfg[pmp_pkg::CFG_S2]) begin
      dt1 = (cfg[pmp_pkg::CFG_S1] && !cfg[pmp_pkg::CFG_S0]) ? (sum_a | sum_b | sum_c)
                                                          : (sum_a | sum_b);
    end else begin
      unique case ({cfg[pmp_pkg::CFG_S1], cfg[pmp_pkg::CFG_S0]})
        2'h0: out_val = sum_a | sum_b;
        2'h1: out_val = sum_a;
        2'h2: out_val = sum_a | sum_b | sum_c;
        2'h3: out_val = cfg[pmp_pkg::CFG_T2] ? (sum_a | sum_b) : sum_a;
      endcase
    end
  end

  assign oe_term = term[pmp_pkg::T_OE];
  // legacy drops pin clocks and toggle flops
  assign clk1 = term[pmp_pkg::T_CLK1] & ((cfg[pmp_pkg::CFG_PCK1] && !legacy) ? pin_clk : 1'h1);
  assign clk2 = term[pmp_pkg::T_CLK2] & ((cfg[pmp_pkg::CFG_PCK2] && !legacy) ? pin_clk : 1'h1);
  assign t1 = cfg[pmp_pkg::CFG_T1] & ~legacy;
  assign t2 = cfg[pmp_pkg::CFG_T2] & ~legacy;
  assign rise1 = clk1 & ~clk1_prev_q;
  assign rise2 = clk2 & ~clk2_prev_q;

  // feedback from flop input or output
  assign second_feedback = (cfg[pmp_pkg::CFG_S1] && cfg[pmp_pkg::CFG_S0] && !legacy)
                           ? buried_flop_input : buried_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clk1_prev_q <= 1'h0;
      clk2_prev_q <= 1'h0;
    end else if (ce) begin
      clk1_prev_q <= clk1;
      clk2_prev_q <= clk2;
    end
  end

  // cleared at reset; force load outranks clear and clock
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      primary_q <= pmp_pkg::FLOP_RST;
    end else if (ce) begin
      if (force_load && !force_buried) begin
        primary_q <= force_data;
      end else if (!force_mode) begin
        if (term[pmp_pkg::T_CLR1]) begin
          primary_q <= 1'h0;
        end else if (rise1) begin
          if (preset_term) begin
            primary_q <= 1'h1;
          end else begin
            primary_q <= t1 ? (primary_q ^ dt1) : dt1;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      buried_q <= pmp_pkg::FLOP_RST;
    end else if (ce) begin
      if (force_load && force_buried) begin
        buried_q <= force_data;
      end else if (!force_mode) begin
        if (term[pmp_pkg::T_CLR2]) begin
          buried_q <= 1'h0;
        end else if (rise2) begin
          buried_q <= t2 ? (buried_q ^ buried_flop_input) : buried_flop_input;
        end
      end
    end
  end

  sequence s_clock1_edge;
    ce && !force_mode && rise1 && !term[pmp_pkg::T_CLR1];
  endsequence

  a_clear_wins: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && !force_load && !force_mode && term[pmp_pkg::T_CLR1] |=> !primary_q)
    else $error("clear term did not clear primary flop");

  a_preset_sets: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_clock1_edge and preset_term && !force_load |=> primary_q)
    else $error("preset term did not set primary flop");

  a_legacy_feedback: assert property (
    @(posedge ref_clk) disable iff (reset)
    legacy |-> second_feedback == buried_q && clk1 == term[pmp_pkg::T_CLK1])
    else $error("legacy mode used a removed feature");

  a_feedback_select: assert property (
    @(posedge ref_clk) disable iff (reset)
    !legacy && cfg[pmp_pkg::CFG_S1] && cfg[pmp_pkg::CFG_S0] |-> second_feedback == sum_c)
    else $error("feedback did not take buried flop input");
endmodule

// ===== hw/pmp_pkg.sv
// shared constants for the macrocell array, force-load and verify port
package pmp_pkg;
  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int NUM_MC = 24;
  localparam int NUM_TERMS = 17;
  localparam int BUS_W = 172;
  localparam int NUM_DIN = 14;
  localparam int NUM_PRESET = 8;
  localparam int SUM_TERMS = 4;
  localparam int MC_BUS_LINES = 6;
  localparam int MC_BUS_BASE = 2 * NUM_DIN;
  localparam int MC_FUSE_W = NUM_TERMS * BUS_W;
  localparam int CFG_W = 8;
  localparam int FUSE_TOTAL = NUM_MC * MC_FUSE_W + NUM_PRESET * BUS_W + NUM_MC * CFG_W;
  localparam int FUSE_IDX_W = 17;

  // ************************************************************
  // product term roles inside one macrocell
  // ************************************************************
  localparam int T_CLR1 = 0;
  localparam int T_CLK1 = 1;
  localparam int T_CLK2 = 2;
  localparam int T_CLR2 = 3;
  localparam int T_OE = 4;
  localparam int T_SUM_BASE = 5;

  // ************************************************************
  // per-macrocell configuration bits
  // ************************************************************
  localparam int CFG_S0 = 0;
  localparam int CFG_S1 = 1;
  localparam int CFG_S2 = 2;
  localparam int CFG_POL = 3;
  localparam int CFG_T1 = 4;
  localparam int CFG_T2 = 5;
  localparam int CFG_PCK1 = 6;
  localparam int CFG_PCK2 = 7;

  // ************************************************************
  // register port
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PRIMARY = 8'h04;
  localparam logic [7:0] OFF_BURIED = 8'h08;
  localparam logic [7:0] OFF_FUSE_ADDR = 8'h0c;
  localparam logic [7:0] OFF_FUSE_DATA = 8'h10;
  localparam int CTRL_LEGACY = 0;
  localparam int CTRL_KEEPER = 1;
  localparam int CTRL_SECURE = 2;
  localparam logic LEGACY_RST = 1'h0;
  localparam logic KEEPER_RST = 1'h0;
  localparam logic SECURE_RST = 1'h0;
  localparam logic FLOP_RST = 1'h0;

  // preset groups alternate four and two macrocells
  function automatic logic [2:0] preset_group(input int m);
    int g;
    g = (m / 6) * 2 + (((m % 6) < 4) ? 0 : 1);
    return 3'(g);
  endfunction
endpackage
